// ===== verilog/fsws_pkg.sv
package fsws_pkg;
  // Register word offsets on the AHB-Lite bus (byte addresses).
  localparam logic [7:0] FSWS_OFS_CONTROL   = 8'h00;
  localparam logic [7:0] FSWS_OFS_KEY       = 8'h04;
  localparam logic [7:0] FSWS_OFS_ADDR_LOW  = 8'h08;
  localparam logic [7:0] FSWS_OFS_ADDR_HIGH = 8'h0C;
  localparam logic [7:0] FSWS_OFS_DATA_LOW  = 8'h10;
  localparam logic [7:0] FSWS_OFS_DATA_HIGH = 8'h14;
  localparam logic [7:0] FSWS_OFS_STATUS    = 8'h18;
  localparam logic [7:0] FSWS_OFS_PROTECT   = 8'h1C;
  // Control register fields, key codes, block layout and field widths.
  localparam int FSWS_BIT_RD   = 0;
  localparam int FSWS_BIT_WR   = 1;
  localparam int FSWS_BIT_PROGRAM_ENABLE_BIT = 2;
  localparam logic [7:0] FSWS_CTRL_FIXED = 8'h80;
  localparam logic [7:0] FSWS_KEY_FIRST  = 8'h55;
  localparam logic [7:0] FSWS_KEY_SECOND = 8'hAA;
  localparam logic [1:0] FSWS_LAST_WORD  = 2'b11;
  localparam int FSWS_WORDS_PER_BLOCK = 4;
  localparam int FSWS_ROW_WORDS       = 16;
  localparam int FSWS_ADDR_W          = 11;
  localparam int FSWS_DATA_W          = 14;
  localparam int FSWS_ADRH_W          = 3;
  localparam int FSWS_DATH_W          = 6;
  // Timing, 100 MHz clock.
  localparam int FSWS_CLK_NS       = 10;
  localparam int FSWS_WRITE_US     = 4000;
  localparam int FSWS_POWER_UP_DELAY_TIMER_US      = 64000;
  localparam int FSWS_WRITE_CYCLES = FSWS_WRITE_US * 1000 / FSWS_CLK_NS;
  localparam int FSWS_POWER_UP_DELAY_TIMER_CYCLES  = FSWS_POWER_UP_DELAY_TIMER_US * 1000 / FSWS_CLK_NS;
  localparam int FSWS_SETUP_CYCLES = 2;
  localparam int FSWS_READ_DELAY   = 2;
  localparam logic [1:0] FSWS_HTRANS_NONSEQ = 2'b10;
  typedef enum logic [2:0] {
    FSWS_IDLE, FSWS_SETUP, FSWS_ERASE, FSWS_PROGRAM, FSWS_READ
  } fsws_state_t;
endpackage : fsws_pkg

// ===== verilog/fsws_sequencer.sv
// Implementation choices: the register offsets and the AHB-Lite register port.
module fsws_sequencer
  import fsws_pkg::*;
#(
  parameter int WRITE_CYCLES = fsws_pkg::FSWS_WRITE_CYCLES,
  parameter int POWER_UP_DELAY_TIMER_CYCLES  = fsws_pkg::FSWS_POWER_UP_DELAY_TIMER_CYCLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Flash array port
  output logic             flash_erase_row,
  output logic             flash_prog_word,
  output logic      [10:0] flash_addr,
  output logic      [13:0] flash_wdata,
  output logic             flash_read,
  input  wire logic [13:0] flash_rdata,
  // Configuration and status
  input  wire logic [1:0]  write_protect_cfg,
  input  wire logic        code_protect,
  output logic             cpu_stall,
  output logic             ext_test_access_en
);
  import fsws_pkg::*;

  logic [7:0]  adrl_q, adrh_q, datl_q, dath_q;
  logic        program_enable_bit_q, wr_q, rd_q;
  logic [1:0]  key_q;
  logic        ap_valid_q, ap_write_q;
  logic [7:0]  ap_addr_q;
  logic [31:0] cnt_q;
  logic [1:0]  widx_q;
  logic [13:0] buf_q [FSWS_WORDS_PER_BLOCK];
  logic [10:0] base_q;
  logic        power_up_delay_timer_busy_q;
  fsws_state_t state_q;

  function automatic logic segment_protected(input logic [10:0] a, input logic [1:0] cfg);
    // Protection grows downward from the top in quarter steps of the array.
    segment_protected = (cfg != 2'b00) && ({1'b0, a[10:9]} >= (3'd4 - {1'b0, cfg}));
  endfunction : segment_protected

  wire wr_go  = ap_valid_q && ap_write_q && ap_addr_q == FSWS_OFS_CONTROL;
  wire key_go = ap_valid_q && ap_write_q && ap_addr_q == FSWS_OFS_KEY;
  wire [10:0] cur_addr = {adrh_q[FSWS_ADRH_W-1:0], adrl_q};
  // A trigger is only honoured with the full key, enable set and no timer running.
  wire trig_ok = wr_go && hwdata[FSWS_BIT_WR] && !wr_q && key_q == 2'd2 && program_enable_bit_q && !power_up_delay_timer_busy_q
                 && state_q == FSWS_IDLE;
  wire rd_ok   = wr_go && hwdata[FSWS_BIT_RD] && !rd_q && state_q == FSWS_IDLE;

  // Address phase capture; every access is answered zero-wait OKAY unless stalled.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q  <= 8'h00;
    end else if (hready) begin
      ap_valid_q <= hsel && htrans == FSWS_HTRANS_NONSEQ;
      ap_write_q <= hwrite;
      ap_addr_q  <= haddr;
    end else begin
      ap_valid_q <= 1'b0;
    end
  end

  // Key sequencer: any other access breaks it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_q <= 2'd0;
    end else if (ap_valid_q) begin
      if (key_go && hwdata[7:0] == FSWS_KEY_FIRST)
        key_q <= 2'd1;
      else if (key_go && key_q == 2'd1 && hwdata[7:0] == FSWS_KEY_SECOND)
        key_q <= 2'd2;
      else
        key_q <= 2'd0;
    end
  end

  // Power-up timer blocks writes after reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_up_delay_timer_busy_q <= 1'b1;
    end else if (state_q == FSWS_IDLE && cnt_q >= POWER_UP_DELAY_TIMER_CYCLES - 1 && power_up_delay_timer_busy_q) begin
      power_up_delay_timer_busy_q <= 1'b0;
    end
  end

  // Software registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adrl_q <= 8'h00;
      adrh_q <= 8'h00;
      datl_q <= 8'h00;
      dath_q <= 8'h00;
      program_enable_bit_q <= 1'b0;
    end else begin
      if (ap_valid_q && ap_write_q) begin
        case (ap_addr_q)
          FSWS_OFS_CONTROL:   program_enable_bit_q <= hwdata[FSWS_BIT_PROGRAM_ENABLE_BIT];
          FSWS_OFS_ADDR_LOW:  adrl_q <= hwdata[7:0];
          FSWS_OFS_ADDR_HIGH: adrh_q <= {5'h00, hwdata[FSWS_ADRH_W-1:0]};
          FSWS_OFS_DATA_LOW:  datl_q <= hwdata[7:0];
          FSWS_OFS_DATA_HIGH: dath_q <= {2'b00, hwdata[FSWS_DATH_W-1:0]};
          default: ;
        endcase
      end
      if (state_q == FSWS_READ && cnt_q == FSWS_READ_DELAY - 1) begin
        datl_q <= flash_rdata[7:0];
        dath_q <= {2'b00, flash_rdata[FSWS_DATA_W-1:8]};
      end
    end
  end

  // Sequencer with trigger bits that only hardware clears.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= FSWS_IDLE;
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      cnt_q   <= 32'h0000_0000;
      widx_q  <= 2'b00;
      base_q  <= 11'h000;
      for (int i = 0; i < FSWS_WORDS_PER_BLOCK; i++) buf_q[i] <= 14'h0000;
    end else begin
      case (state_q)
        FSWS_IDLE: begin
          cnt_q <= power_up_delay_timer_busy_q ? cnt_q + 32'd1 : 32'h0000_0000;
          if (trig_ok) begin
            // Buffer entry chosen by the low address bits keeps one block aligned.
            buf_q[adrl_q[1:0]] <= {dath_q[FSWS_DATH_W-1:0], datl_q};
            wr_q  <= 1'b1;
            cnt_q <= 32'h0000_0000;
            state_q <= FSWS_SETUP;
          end else if (rd_ok) begin
            rd_q  <= 1'b1;
            cnt_q <= 32'h0000_0000;
            state_q <= FSWS_READ;
          end
        end
        FSWS_SETUP: begin
          cnt_q <= cnt_q + 32'd1;
          if (cnt_q == FSWS_SETUP_CYCLES - 1) begin
            cnt_q <= 32'h0000_0000;
            if (adrl_q[1:0] == FSWS_LAST_WORD) begin
              base_q  <= {cur_addr[10:2], 2'b00};
              state_q <= FSWS_ERASE;
            end else begin
              wr_q    <= 1'b0;
              state_q <= FSWS_IDLE;
            end
          end
        end
        FSWS_ERASE: begin
          cnt_q <= cnt_q + 32'd1;
          if (cnt_q == WRITE_CYCLES - 1) begin
            cnt_q   <= 32'h0000_0000;
            widx_q  <= 2'b00;
            state_q <= FSWS_PROGRAM;
          end
        end
        FSWS_PROGRAM: begin
          widx_q <= widx_q + 2'd1;
          if (widx_q == FSWS_LAST_WORD) begin
            wr_q    <= 1'b0;
            state_q <= FSWS_IDLE;
          end
        end
        FSWS_READ: begin
          cnt_q <= cnt_q + 32'd1;
          if (cnt_q == FSWS_READ_DELAY - 1) begin
            rd_q    <= 1'b0;
            state_q <= FSWS_IDLE;
          end
        end
        default: state_q <= FSWS_IDLE;
      endcase
    end
  end

  // Flash port and stall, all from flip-flops.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_erase_row    <= 1'b0;
      flash_prog_word    <= 1'b0;
      flash_addr         <= 11'h000;
      flash_wdata        <= 14'h0000;
      flash_read         <= 1'b0;
      cpu_stall          <= 1'b0;
      ext_test_access_en <= 1'b0;
    end else begin
      // A protected row is not erased either, or its contents would be lost.
      flash_erase_row <= state_q == FSWS_SETUP && cnt_q == FSWS_SETUP_CYCLES - 1
                         && adrl_q[1:0] == FSWS_LAST_WORD
                         && !segment_protected(cur_addr, write_protect_cfg);
      flash_prog_word <= state_q == FSWS_PROGRAM
                         && !segment_protected(base_q + {9'h000, widx_q}, write_protect_cfg);
      flash_addr  <= state_q == FSWS_PROGRAM ? base_q + {9'h000, widx_q} : cur_addr;
      flash_wdata <= buf_q[widx_q];
      flash_read  <= rd_ok;
      cpu_stall   <= (state_q == FSWS_SETUP && cnt_q == FSWS_SETUP_CYCLES - 1
                      && adrl_q[1:0] == FSWS_LAST_WORD)
                     || state_q == FSWS_ERASE
                     || (state_q == FSWS_PROGRAM && widx_q != FSWS_LAST_WORD);
      ext_test_access_en <= !code_protect;
    end
  end

  // Read data and bus stall: the bus waits during the long write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= !(state_q == FSWS_SETUP && cnt_q == FSWS_SETUP_CYCLES - 1
                     && adrl_q[1:0] == FSWS_LAST_WORD) && state_q != FSWS_ERASE
                   && !(state_q == FSWS_PROGRAM && widx_q != FSWS_LAST_WORD);
      hrdata <= 32'h0000_0000;
      if (hready && hsel && htrans == FSWS_HTRANS_NONSEQ && !hwrite) begin
        case (haddr)
          FSWS_OFS_CONTROL:   hrdata <= {24'h00_0000, FSWS_CTRL_FIXED | {5'h00, program_enable_bit_q, wr_q, rd_q}};
          FSWS_OFS_KEY:       hrdata <= 32'h0000_0000;
          FSWS_OFS_ADDR_LOW:  hrdata <= {24'h00_0000, adrl_q};
          FSWS_OFS_ADDR_HIGH: hrdata <= {24'h00_0000, adrh_q};
          FSWS_OFS_DATA_LOW:  hrdata <= {24'h00_0000, datl_q};
          FSWS_OFS_DATA_HIGH: hrdata <= {24'h00_0000, dath_q};
          FSWS_OFS_STATUS:    hrdata <= {28'h000_0000, power_up_delay_timer_busy_q, key_q, state_q != FSWS_IDLE};
          default:            hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  a_program_enable_bit_reset_clear: assert property (@(posedge hclk) $rose(hresetn) |-> !program_enable_bit_q && !wr_q)
    else $error("enable or trigger set after reset");
  a_key_required: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(wr_q) |-> $past(key_q) == 2'd2 && $past(program_enable_bit_q))
    else $error("write started without key");
  a_no_early_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(wr_q) |-> $past(state_q) inside {FSWS_SETUP, FSWS_PROGRAM})
    else $error("write trigger cleared early");
  a_short_write: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(wr_q) && adrl_q[1:0] != FSWS_LAST_WORD |-> ##2 !wr_q && !cpu_stall)
    else $error("buffer load did not finish");
  a_erase_last: assert property (@(posedge hclk) disable iff (!hresetn)
    flash_erase_row |-> $past(adrl_q[1:0]) == FSWS_LAST_WORD)
    else $error("erase on wrong word");
  a_key_read_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    hready && hsel && htrans == FSWS_HTRANS_NONSEQ && !hwrite && haddr == FSWS_OFS_KEY
    |=> hrdata == 32'h0000_0000)
    else $error("key port read nonzero");
  a_power_up_delay_timer_inhibit: assert property (@(posedge hclk) disable iff (!hresetn)
    power_up_delay_timer_busy_q |-> !$rose(wr_q))
    else $error("write during power-up timer");
  a_read_latency: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(rd_q) |-> rd_q ##2 !rd_q)
    else $error("read took wrong time");
  a_protected_skip: assert property (@(posedge hclk) disable iff (!hresetn)
    flash_prog_word |-> !segment_protected(flash_addr, write_protect_cfg))
    else $error("programmed protected word");
  c_buffer_load: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(wr_q) && adrl_q[1:0] == 2'b00);
  c_long_write: cover property (@(posedge hclk) disable iff (!hresetn) flash_erase_row);
  c_flash_read: cover property (@(posedge hclk) disable iff (!hresetn) $fell(rd_q));
endmodule : fsws_sequencer

// ===== verification/fsws_flash_model.sv
// Behavioural flash array: erases rows and programs words on the pulses.
module fsws_flash_model (
  // Clock
  input  wire logic        hclk,
  // Array port
  input  wire logic        flash_erase_row,
  input  wire logic        flash_prog_word,
  input  wire logic [10:0] flash_addr,
  input  wire logic [13:0] flash_wdata,
  output logic      [13:0] flash_rdata,
  // Activity counts
  output int               erase_cnt,
  output int               prog_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] mem [0:2047];
  initial begin
    erase_cnt = 0;
    prog_cnt = 0;
    for (int i = 0; i < 2048; i++) begin
      mem[i] = {3'h3, 11'(i)};
    end
  end
  // The read port is combinational from the address, like the real array.
  assign flash_rdata = mem[flash_addr];
  always @(posedge hclk) begin
    if (flash_erase_row) begin
      for (int j = 0; j < 16; j++) begin
        mem[{flash_addr[10:4], 4'(j)}] = 14'h3FFF;
      end
      erase_cnt++;
    end
    if (flash_prog_word) begin
      mem[flash_addr] = flash_wdata;
      prog_cnt++;
    end
  end
endmodule : fsws_flash_model

// ===== verification/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fsws_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        code_protect = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0, write_protect_cfg = 2'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, ers, prg, frd, cpu_stall, ext_en;
  logic [10:0] fa;
  logic [13:0] fwd, frdat;
  int          num_errors = 0, samples_checked = 0, stall_cyc = 0;
  int          erase_cnt, prog_cnt, e0, p0, s0;
  fsws_sequencer #(.WRITE_CYCLES(20), .POWER_UP_DELAY_TIMER_CYCLES(30)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .flash_erase_row(ers), .flash_prog_word(prg), .flash_addr(fa),
    .flash_wdata(fwd), .flash_read(frd), .flash_rdata(frdat),
    .write_protect_cfg(write_protect_cfg), .code_protect(code_protect),
    .cpu_stall(cpu_stall), .ext_test_access_en(ext_en));
  fsws_flash_model flash_u (
    .hclk(hclk), .flash_erase_row(ers), .flash_prog_word(prg), .flash_addr(fa),
    .flash_wdata(fwd), .flash_rdata(frdat), .erase_cnt(erase_cnt), .prog_cnt(prog_cnt));
  initial begin
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (cpu_stall === 1'b1) stall_cyc++;
  end
  task stop_test;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  task check(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check
  // Ready is looked at on the falling edge, so it is the value the next rising edge sees.
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 2000);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      $display("MISMATCH t=%0t bus timeout", $time);
      stop_test();
    end
  endtask : wait_rdy
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= FSWS_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    wait_rdy();
    r = hrdata;
    @(posedge hclk);
  endtask : xfer
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e, input string m);
    logic [31:0] r;
    xfer(1'b0, a, 8'h00, r);
    check(r, {24'h00_0000, e}, m);
    check({31'h0000_0000, hresp}, 32'h0000_0000, "hresp okay");
  endtask : rd
  task set_addr(input logic [10:0] a);
    wr(FSWS_OFS_ADDR_LOW, a[7:0]);
    wr(FSWS_OFS_ADDR_HIGH, {5'h00, a[10:8]});
  endtask : set_addr
  // Key pair, trigger, then the two idle cycles the set-up needs.
  task unlock(input logic [7:0] c);
    wr(FSWS_OFS_KEY, FSWS_KEY_FIRST);
    wr(FSWS_OFS_KEY, FSWS_KEY_SECOND);
    wr(FSWS_OFS_CONTROL, c);
    repeat (2) @(posedge hclk);
  endtask : unlock
  task word(input logic [10:0] a);
    set_addr(a);
    wr(FSWS_OFS_DATA_LOW, a[7:0]);
    wr(FSWS_OFS_DATA_HIGH, {3'h0, 2'h1, a[10:8]});
    unlock(8'h06);
  endtask : word
  task block(input logic [10:0] b, input int ne);
    s0 = stall_cyc;
    e0 = erase_cnt;
    p0 = prog_cnt;
    for (int i = 0; i < 3; i++) word(b + 11'(i));
    check(32'(stall_cyc - s0), 32'h0000_0000, "early stall");
    check(32'(erase_cnt), 32'(e0), "early erase");
    word(b + 11'h003);
    rd(FSWS_OFS_CONTROL, 8'h84, "long write done");
    check(32'(erase_cnt), 32'(e0 + ne), "erase count");
    check(32'(stall_cyc - s0 >= 20), 32'h0000_0001, "stall length");
  endtask : block
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // Trigger inside the power-up window must be ignored.
    set_addr(11'h013);
    wr(FSWS_OFS_CONTROL, 8'h04);
    unlock(8'h06);
    check(32'(erase_cnt), 32'h0000_0000, "write in timer");
    // A second reset in mid-run must bring the control, address and data registers back.
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(FSWS_OFS_CONTROL, FSWS_CTRL_FIXED, "ctrl reset");
    rd(FSWS_OFS_ADDR_LOW, 8'h00, "addrl reset");
    rd(FSWS_OFS_ADDR_HIGH, 8'h00, "addrh reset");
    rd(FSWS_OFS_DATA_LOW, 8'h00, "datal reset");
    rd(FSWS_OFS_DATA_HIGH, 8'h00, "datah reset");
    rd(FSWS_OFS_KEY, 8'h00, "key read");
    rd(8'h20, 8'h00, "unmapped read");
    check({31'h0000_0000, ext_en}, 32'h0000_0001, "test access on");
    repeat (40) @(posedge hclk);
    set_addr(11'h013);
    wr(FSWS_OFS_CONTROL, 8'h00);
    unlock(8'h02);
    check(32'(erase_cnt), 32'h0000_0000, "write without enable");
    wr(FSWS_OFS_CONTROL, 8'h04);
    wr(FSWS_OFS_KEY, FSWS_KEY_FIRST);
    rd(FSWS_OFS_ADDR_LOW, 8'h13, "addrl rw");
    wr(FSWS_OFS_KEY, FSWS_KEY_SECOND);
    wr(FSWS_OFS_CONTROL, 8'h06);
    repeat (2) @(posedge hclk);
    check(32'(erase_cnt), 32'h0000_0000, "broken key");
    block(11'h010, 1);
    check(32'(prog_cnt), 32'(p0 + 4), "prog count");
    rd(FSWS_OFS_CONTROL, 8'h84, "wr cleared");
    for (int i = 0; i < 4; i++) begin
      check(32'(flash_u.mem[16 + i]), 32'({3'h1, 11'(16 + i)}), "word");
    end
    check(32'(flash_u.mem[20]), 32'h0000_3FFF, "row erased");
    check(32'(flash_u.mem[15]), 32'h0000_180F, "other row");
    set_addr(11'h020);
    wr(FSWS_OFS_CONTROL, 8'h05);
    repeat (2) @(posedge hclk);
    rd(FSWS_OFS_DATA_LOW, 8'h20, "read low");
    rd(FSWS_OFS_DATA_HIGH, 8'h18, "read high");
    write_protect_cfg <= 2'h3;
    block(11'h700, 0);
    check(32'(prog_cnt), 32'(p0), "protected prog");
    write_protect_cfg <= 2'h0;
    code_protect <= 1'b1;
    repeat (3) @(posedge hclk);
    check({31'h0000_0000, ext_en}, 32'h0000_0000, "test access off");
    stop_test();
  end
endmodule : tb_top
